// ### hw/prc_pkg.sv
package prc_pkg;

    // command opcodes
    localparam logic [7:0] OPC_REFRESH_BUF1 = 8'h58;
    localparam logic [7:0] OPC_REFRESH_BUF2 = 8'h59;
    localparam logic [7:0] OPC_STATUS_READ  = 8'hd7;

    // serial framing
    localparam logic [5:0] OPCODE_LAST_BIT  = 6'h07;
    localparam logic [5:0] CMD_LAST_BIT     = 6'h1f;
    localparam logic [5:0] DATA_FIRST_BIT   = 6'h20;
    localparam logic [5:0] BIT_CNT_SAT      = 6'h21;
    localparam logic [2:0] OUT_LAST_BIT     = 3'h7;

    // page index position inside the 24 address bits
    localparam int PAGE_BITS   = 11;
    localparam int STD_PAGE_LSB = 9;
    localparam int BIN_PAGE_LSB = 8;

    // status byte one
    localparam int ST1_READY_BIT     = 7;
    localparam int ST1_COMPARE_BIT   = 6;
    localparam int ST1_DENSITY_LSB   = 2;
    localparam int ST1_PROTECT_BIT   = 1;
    localparam int ST1_PAGE_SIZE_BIT = 0;
    // status byte two
    localparam int ST2_READY_BIT     = 7;
    localparam int ST2_PROG_ERR_BIT  = 5;
    localparam int ST2_LOCKDOWN_BIT  = 3;
    localparam int ST2_PS2_BIT       = 2;
    localparam int ST2_PS1_BIT       = 1;
    localparam int ST2_ES_BIT        = 0;
    // arbitrary value, not a real part's code
    localparam logic [3:0] DENSITY_CODE_DEFAULT = 4'h5;

    // timing
    localparam int CLK_FREQ_MHZ        = 20;
    localparam int REWRITE_MAX_TIME_US = 20000;
    localparam int REWRITE_MAX_CYCLES  = REWRITE_MAX_TIME_US * CLK_FREQ_MHZ;
    localparam int COPY_CYCLES_DEFAULT = REWRITE_MAX_CYCLES / 8;
    localparam int PROG_CYCLES_DEFAULT = REWRITE_MAX_CYCLES / 2;
    localparam int TIMER_W             = 20;

    typedef enum logic [2:0] {CMD_NONE, CMD_REFRESH, CMD_RMW, CMD_STATUS, CMD_OTHER} prc_cmd_e;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_COPY, SEQ_PROGRAM} prc_seq_e;

    typedef struct packed {
        logic [7:0] byte_one;
        logic [7:0] byte_two;
    } prc_status_s;

    typedef struct packed {
        logic                 copy;
        logic                 write_back;
        logic [PAGE_BITS-1:0] page;
        logic                 second_buffer;
    } prc_array_req_s;

    typedef struct packed {
        logic compare_mismatch;
        logic sector_protect;
        logic page_size_binary;
        logic program_error;
        logic lockdown_enabled;
        logic suspend_second;
        logic suspend_first;
        logic erase_suspend;
    } prc_flags_s;

endpackage : prc_pkg

// ### hw/prc_sync.sv
`timescale 1ns/1ps
module prc_sync
    import prc_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage_one;
        logic [WIDTH-1:0] stage_two;
    } prc_sync_s;

    prc_sync_s state;
    prc_sync_s next_state;

    always_comb
    begin
        next_state.stage_one = d_in;
        next_state.stage_two = state.stage_one;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            state <= '0;
        else
            state <= next_state;
    end

    assign q_out = state.stage_two;
endmodule : prc_sync

// ### hw/prc_op_timer.sv
`timescale 1ns/1ps
module prc_op_timer
    import prc_pkg::*;
(
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    input  wire logic               start_in,
    input  wire logic [TIMER_W-1:0] load_in,
    output logic                    busy_out,
    output logic                    done_out
);
    typedef struct packed {
        logic [TIMER_W-1:0] count;
        logic               done;
    } prc_timer_s;

    prc_timer_s state;
    prc_timer_s next_state;

    always_comb
    begin
        next_state      = state;
        next_state.done = 1'b0;
        if (start_in)
            next_state.count = load_in;
        else if (state.count != '0)
        begin
            next_state.count = state.count - TIMER_W'(1);
            next_state.done  = (state.count == TIMER_W'(1));
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            state <= '0;
        else
            state <= next_state;
    end

    assign busy_out = (state.count != '0);
    assign done_out = state.done;
endmodule : prc_op_timer

// ### hw/prc_refresh_status.sv
`timescale 1ns/1ps
module prc_refresh_status
    import prc_pkg::*;
#(
    parameter int         COPY_CYCLES  = COPY_CYCLES_DEFAULT,
    parameter int         PROG_CYCLES  = PROG_CYCLES_DEFAULT,
    parameter logic [3:0] DENSITY_CODE = DENSITY_CODE_DEFAULT
)
(
    input  wire logic     ref_clk_in,
    input  wire logic     rst_n_in,
    input  wire logic     sck_in,
    input  wire logic     cs_n_in,
    input  wire logic     si_in,
    output logic          so_data_out,
    output logic          so_oe_out,
    input  wire prc_flags_s flags_in,
    input  wire logic     ext_busy_in,
    output prc_array_req_s array_req_out,
    output logic          ready_out
);

    // link side, cleared by the frame itself (select high)
    typedef struct packed {
        logic [5:0]  bit_cnt;
        logic [30:0] in_shift;
        logic        reading;
        logic [7:0]  out_shift;
        logic [2:0]  out_bits;
        logic        byte_two;
    } prc_frame_s;

    // link side, kept after the frame so the core can pick it up
    typedef struct packed {
        prc_cmd_e    kind;
        logic        second_buffer;
        logic [23:0] addr;
        logic        tag;
    } prc_cmd_s;

    // core side
    typedef struct packed {
        prc_seq_e             seq;
        logic                 select_prev;
        logic                 timer_start;
        logic [TIMER_W-1:0]   timer_load;
        logic [PAGE_BITS-1:0] page;
        logic                 second_buffer;
        prc_status_s          status;
        logic                 tag_seen;
    } prc_core_s;

    prc_frame_s  frame;
    prc_frame_s  next_frame;
    prc_cmd_s    cmd;
    prc_cmd_s    next_cmd;
    prc_core_s   core;
    prc_core_s   next_core;

    logic        frame_rst_n;
    prc_status_s link_status;
    logic        select_sync;
    logic        timer_busy;
    logic        timer_done;
    logic        ready;
    logic [31:0] cmd_word;
    logic [7:0]  opcode_now;
    logic        select_rise;
    logic        fresh_cmd;

    // select high acts as the frame's reset: sck may stop at any time, so
    // nothing may wait for a further edge to end the readout
    assign frame_rst_n = rst_n_in & ~cs_n_in;

    prc_sync #(
        .WIDTH (16)
    ) u_status_sync (
        .clk_in   (sck_in),
        .rst_n_in (rst_n_in),
        .d_in     (core.status),
        .q_out    (link_status)
    );

    prc_sync #(
        .WIDTH (1)
    ) u_select_sync (
        .clk_in   (ref_clk_in),
        .rst_n_in (rst_n_in),
        .d_in     (~cs_n_in),
        .q_out    (select_sync)
    );

    prc_op_timer u_timer (
        .clk_in   (ref_clk_in),
        .rst_n_in (rst_n_in),
        .start_in (core.timer_start),
        .load_in  (core.timer_load),
        .busy_out (timer_busy),
        .done_out (timer_done)
    );

    // link domain: mode 0, data in sampled and data out updated on rising sck
    always_comb
    begin
        next_frame = frame;
        next_cmd   = cmd;
        cmd_word   = {frame.in_shift, si_in};
        opcode_now = cmd_word[7:0];

        if (frame.bit_cnt != BIT_CNT_SAT)
            next_frame.bit_cnt = frame.bit_cnt + 6'h01;
        next_frame.in_shift = cmd_word[30:0];

        if (frame.bit_cnt == '0)
            next_cmd.kind = CMD_OTHER;

        if (frame.bit_cnt == OPCODE_LAST_BIT)
        begin
            if (opcode_now == OPC_STATUS_READ)
            begin
                next_cmd.kind        = CMD_STATUS;
                next_frame.reading   = 1'b1;
                next_frame.out_shift = link_status.byte_one;
                next_frame.out_bits  = '0;
                next_frame.byte_two  = 1'b0;
            end
        end

        if (frame.bit_cnt == CMD_LAST_BIT)
        begin
            if (cmd_word[31:24] == OPC_REFRESH_BUF1 || cmd_word[31:24] == OPC_REFRESH_BUF2)
            begin
                next_cmd.kind          = CMD_REFRESH;
                next_cmd.second_buffer = cmd_word[24];
                next_cmd.addr          = cmd_word[23:0];
                // toggles once per captured refresh so the core can tell a new one
                next_cmd.tag           = ~cmd.tag;
            end
        end

        // any data bit after the address turns the refresh into read-modify-write
        if (frame.bit_cnt == DATA_FIRST_BIT && cmd.kind == CMD_REFRESH)
            next_cmd.kind = CMD_RMW;

        if (frame.reading)
        begin
            if (frame.out_bits == OUT_LAST_BIT)
            begin
                // reload from the live copy at every byte boundary
                next_frame.out_bits  = '0;
                next_frame.byte_two  = ~frame.byte_two;
                next_frame.out_shift = frame.byte_two ? link_status.byte_one
                                                      : link_status.byte_two;
            end
            else
            begin
                next_frame.out_bits  = frame.out_bits + 3'h1;
                next_frame.out_shift = {frame.out_shift[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sck_in or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            frame <= '0;
        else
            frame <= next_frame;
    end

    always_ff @(posedge sck_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cmd      <= '0;
            cmd.kind <= CMD_NONE;
        end
        else
            cmd <= next_cmd;
    end

    assign so_data_out = frame.out_shift[7];
    assign so_oe_out   = frame.reading;

    // core domain
    assign ready = ~(timer_busy | ext_busy_in | (core.seq != SEQ_IDLE));

    always_comb
    begin
        next_core             = core;
        next_core.select_prev = select_sync;
        next_core.timer_start = 1'b0;
        select_rise           = core.select_prev && !select_sync;
        fresh_cmd             = (cmd.tag != core.tag_seen);
        // every select rise uses up the command behind it, refused or not, so a
        // later frame without clock edges cannot replay an old refresh
        if (select_rise)
            next_core.tag_seen = cmd.tag;

        // status word is rebuilt every cycle; reading it has no side effect
        next_core.status.byte_one                   = '0;
        next_core.status.byte_one[ST1_READY_BIT]    = ready;
        next_core.status.byte_one[ST1_COMPARE_BIT]  = flags_in.compare_mismatch;
        next_core.status.byte_one[ST1_DENSITY_LSB +: 4] = DENSITY_CODE;
        next_core.status.byte_one[ST1_PROTECT_BIT]  = flags_in.sector_protect;
        next_core.status.byte_one[ST1_PAGE_SIZE_BIT] = flags_in.page_size_binary;
        next_core.status.byte_two                   = '0;
        next_core.status.byte_two[ST2_READY_BIT]    = ready;
        next_core.status.byte_two[ST2_PROG_ERR_BIT] = flags_in.program_error;
        next_core.status.byte_two[ST2_LOCKDOWN_BIT] = flags_in.lockdown_enabled;
        next_core.status.byte_two[ST2_PS2_BIT]      = flags_in.suspend_second;
        next_core.status.byte_two[ST2_PS1_BIT]      = flags_in.suspend_first;
        next_core.status.byte_two[ST2_ES_BIT]       = flags_in.erase_suspend;

        unique case (core.seq)
            SEQ_IDLE:
            begin
                // the command fields stopped moving when select rose, and the
                // synchronised edge arrives later, so they are read stable here
                if (select_rise && fresh_cmd && cmd.kind == CMD_REFRESH && !ext_busy_in)
                begin
                    next_core.seq           = SEQ_COPY;
                    next_core.second_buffer = cmd.second_buffer;
                    next_core.timer_start   = 1'b1;
                    next_core.timer_load    = TIMER_W'(COPY_CYCLES);
                    if (flags_in.page_size_binary)
                        next_core.page = cmd.addr[BIN_PAGE_LSB +: PAGE_BITS];
                    else
                        next_core.page = cmd.addr[STD_PAGE_LSB +: PAGE_BITS];
                end
            end
            SEQ_COPY:
            begin
                if (timer_done)
                begin
                    next_core.seq         = SEQ_PROGRAM;
                    next_core.timer_start = 1'b1;
                    next_core.timer_load  = TIMER_W'(PROG_CYCLES);
                end
            end
            SEQ_PROGRAM:
            begin
                if (timer_done)
                    next_core.seq = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            core     <= '0;
            core.seq <= SEQ_IDLE;
        end
        else
            core <= next_core;
    end

    always_comb
    begin
        array_req_out.copy          = (core.seq == SEQ_COPY);
        array_req_out.write_back    = (core.seq == SEQ_PROGRAM);
        array_req_out.page          = core.page;
        array_req_out.second_buffer = core.second_buffer;
    end

    assign ready_out = core.status.byte_one[ST1_READY_BIT];

endmodule : prc_refresh_status

// ### dv/prc_refresh_status_asserts.sv
`timescale 1ns/1ps
module prc_refresh_status_asserts
    import prc_pkg::*;
#(
    parameter int COPY_CYCLES = COPY_CYCLES_DEFAULT,
    parameter int PROG_CYCLES = PROG_CYCLES_DEFAULT
)
(
    input wire logic           ref_clk_in,
    input wire logic           rst_n_in,
    input wire logic           sck_in,
    input wire logic           cs_n_in,
    input wire logic           si_in,
    input wire logic           so_data_out,
    input wire logic           so_oe_out,
    input wire prc_flags_s     flags_in,
    input wire logic           ext_busy_in,
    input wire prc_array_req_s array_req_out,
    input wire logic           ready_out
);
    localparam int COPY_MAX = COPY_CYCLES + 3;
    localparam int PROG_MAX = PROG_CYCLES + 3;
    logic [TIMER_W-1:0] copy_len;
    logic [TIMER_W-1:0] prog_len;
    // phase lengths are counted, as they run far past what a delay may span
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            copy_len <= '0;
            prog_len <= '0;
        end
        else
        begin
            copy_len <= array_req_out.copy ? copy_len + TIMER_W'(1) : '0;
            prog_len <= array_req_out.write_back ? prog_len + TIMER_W'(1) : '0;
        end
    end
    logic [5:0] edges;
    logic [7:0] op_sr;
    // cleared by select like the frame logic, so it always counts from the frame start
    always_ff @(posedge sck_in or posedge cs_n_in or negedge rst_n_in)
    begin
        if (!rst_n_in || cs_n_in)
        begin
            edges <= 6'h00;
            op_sr <= 8'h00;
        end
        else
        begin
            edges <= (edges == 6'h3f) ? edges : edges + 6'h01;
            op_sr <= (edges < 6'h08) ? {op_sr[6:0], si_in} : op_sr;
        end
    end
    property p_oe_released;
        @(posedge ref_clk_in) disable iff (!rst_n_in) cs_n_in |-> !so_oe_out;
    endproperty
    a_oe_released: assert property (p_oe_released) else $error("output driven while deselected");
    property p_oe_at_opcode;
        @(posedge sck_in) disable iff (!rst_n_in || cs_n_in)
            $rose(so_oe_out) |-> edges == 6'h08 && op_sr == OPC_STATUS_READ;
    endproperty
    a_oe_at_opcode: assert property (p_oe_at_opcode) else $error("output enabled at wrong point");
    property p_copy_len;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
            $fell(array_req_out.copy) |-> (copy_len >= COPY_CYCLES && copy_len <= COPY_MAX)
            ##[0:2] array_req_out.write_back;
    endproperty
    a_copy_len: assert property (p_copy_len) else $error("copy phase length or order wrong");
    property p_prog_len;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
            $fell(array_req_out.write_back) |-> prog_len >= PROG_CYCLES && prog_len <= PROG_MAX;
    endproperty
    a_prog_len: assert property (p_prog_len) else $error("program phase length wrong");
    property p_busy_shown;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
            (array_req_out.copy || array_req_out.write_back) [*2] |-> !ready_out;
    endproperty
    a_busy_shown: assert property (p_busy_shown) else $error("ready shown during rewrite");
    property p_ext_busy;
        @(posedge ref_clk_in) disable iff (!rst_n_in) ext_busy_in |=> !ready_out;
    endproperty
    a_ext_busy: assert property (p_ext_busy) else $error("ready shown during other operation");
    property p_ready_back;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
            $fell(array_req_out.write_back) && !ext_busy_in |-> ##[1:2] ready_out;
    endproperty
    a_ready_back: assert property (p_ready_back) else $error("ready not restored");
    property p_page_hold;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
            $past(array_req_out.copy || array_req_out.write_back) && array_req_out.write_back
            |-> $stable(array_req_out.page) && $stable(array_req_out.second_buffer);
    endproperty
    a_page_hold: assert property (p_page_hold) else $error("page changed during rewrite");
    c_refresh: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) $rose(array_req_out.write_back));
    c_status: cover property (@(posedge sck_in) disable iff (!rst_n_in || cs_n_in) $rose(so_oe_out));
    c_ext: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) ext_busy_in && !ready_out);
endmodule : prc_refresh_status_asserts

bind prc_refresh_status prc_refresh_status_asserts #(.COPY_CYCLES(COPY_CYCLES), .PROG_CYCLES(PROG_CYCLES)) u_chk (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sck_in(sck_in), .cs_n_in(cs_n_in), .si_in(si_in),
    .so_data_out(so_data_out), .so_oe_out(so_oe_out), .flags_in(flags_in), .ext_busy_in(ext_busy_in),
    .array_req_out(array_req_out), .ready_out(ready_out));

// ### dv/prc_host_model.sv
`timescale 1ns/1ps
module prc_host_model (
    output logic     sck_out,
    output logic     cs_n_out,
    output logic     si_out,
    input wire logic so_data_in,
    input wire logic so_oe_in
);
    initial
    begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end
    // clock runs only inside a frame; read bits are taken at the falling edge, half a period before the next rising edge
    task automatic frame(input int nbits, input logic [63:0] mosi, input int nrd, output logic [63:0] miso);
        miso = '0;
        cs_n_out = 1'b0;
        for (int i = 0; i < nbits + nrd; i++)
        begin
            sck_out = 1'b0;
            si_out = (i < nbits) ? mosi[nbits-1-i] : ~si_out;
            if (i >= nbits)
                miso = {miso[62:0], so_oe_in ? so_data_in : 1'bx};
            #32;
            sck_out = 1'b1;
            #32;
        end
        sck_out = 1'b0;
        #32;
        cs_n_out = 1'b1;
        si_out = ~si_out;
    endtask : frame
endmodule : prc_host_model

// ### dv/prc_refresh_status_test.sv
`timescale 1ns/1ps
module prc_refresh_status_test;
    import prc_pkg::*;
    localparam logic [3:0] DENS = 4'ha; // arbitrary density code
    logic           ref_clk_in, rst_n_in, sck, cs_n, si, so_data, so_oe, ext_busy_in, ready_out, prev_copy;
    prc_flags_s     flags_in;
    prc_array_req_s array_req_out;
    logic [11:0]    exp_q[$];
    logic [31:0]    seed;
    int             error_cnt, compares, cycles;

    always #25 ref_clk_in = ~ref_clk_in;

    prc_refresh_status #(.COPY_CYCLES(20), .PROG_CYCLES(40), .DENSITY_CODE(DENS)) uut (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
        .so_data_out(so_data), .so_oe_out(so_oe), .flags_in(flags_in), .ext_busy_in(ext_busy_in),
        .array_req_out(array_req_out), .ready_out(ready_out));
    prc_host_model host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_data_in(so_data), .so_oe_in(so_oe));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic chk_st(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: status stream %h expected %h", $time, got, exp);
        end
    endtask : chk_st

    task automatic chk_req(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: array request %h expected %h", $time, got, exp);
        end
    endtask : chk_req

    task automatic gap();
        repeat (4) @(posedge ref_clk_in);
        #1;
    endtask : gap

    task automatic status(input int nrd, input logic rdy);
        logic [63:0] miso;
        logic [7:0]  b1, b2;
        b1 = {rdy, flags_in.compare_mismatch, DENS, flags_in.sector_protect, flags_in.page_size_binary};
        b2 = {rdy, 1'b0, flags_in.program_error, 1'b0, flags_in.lockdown_enabled, flags_in.suspend_second,
              flags_in.suspend_first, flags_in.erase_suspend};
        host.frame(8, {56'h0, OPC_STATUS_READ}, nrd, miso);
        chk_st(miso[23:0], {b1, b2, b1} >> (24 - nrd));
        gap();
    endtask : status

    task automatic refresh(input logic sb, input logic [23:0] addr, input logic rmw, input logic go);
        logic [63:0] miso;
        logic [10:0] page;
        page = flags_in.page_size_binary ? addr[18:8] : addr[19:9];
        if (go && !rmw)
            exp_q.push_back({page, sb});
        host.frame(rmw ? 40 : 32, {24'h0, sb ? OPC_REFRESH_BUF2 : OPC_REFRESH_BUF1, addr, 8'h5a} >> (rmw ? 0 : 8),
                   0, miso);
        gap();
    endtask : refresh

    task automatic tally_and_finish();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // requests are judged mid-cycle so the edge that sets them has settled
    always @(negedge ref_clk_in)
    begin
        cycles++;
        if (cycles > 10000)
        begin
            error_cnt++;
            tally_and_finish();
        end
        if (rst_n_in && array_req_out.copy && !prev_copy)
            chk_req({array_req_out.page, array_req_out.second_buffer},
                    exp_q.size() ? exp_q.pop_front() : ~{array_req_out.page, array_req_out.second_buffer});
        prev_copy = array_req_out.copy;
    end

    initial
    begin
        {ref_clk_in, rst_n_in, ext_busy_in, prev_copy} = 4'h0;
        flags_in = '0;
        seed = 32'h855187eb;
        {error_cnt, compares, cycles} = '0;
        repeat (2) @(posedge ref_clk_in);
        #1 rst_n_in = 1'b1;
        gap();
        for (int k = 0; k < 8; k++)
        begin
            seed = xs(seed);
            @(posedge ref_clk_in);
            #1;
            flags_in = prc_flags_s'(seed[7:0]);
            ext_busy_in = seed[8] & seed[9];
            gap();
            status(24, !ext_busy_in);
            status(5, !ext_busy_in);
            refresh(seed[10], seed[31:8], 1'b0, !ext_busy_in);
            if (!ext_busy_in)
            begin
                status(24, 1'b0);
                for (int n = 0; n < 200 && ready_out !== 1'b1; n++)
                begin
                    @(posedge ref_clk_in);
                    #1;
                end
                chk_st({23'h000000, ready_out}, 24'h000001);
            end
            refresh(seed[11], seed[23:0], 1'b1, 1'b0);
        end
        chk_req(12'(exp_q.size()), 12'h000);
        tally_and_finish();
    end
endmodule : prc_refresh_status_test
